// [acrb_chk.sv]
/* Port assertions of the register bank.
   Assumes a bind to acrb_top. */
`timescale 1ns/10ps
module acrb_chk (
  input logic        CLK_SYS, RSTN, REG_WR, REG_RD, REG_RVALID,
  input logic [3:0]  REG_ADDR,
  input logic [15:0] REG_WDATA, REG_RDATA, MAIN_CONFIG,
  input logic        EXTENDED_CONTROL_MODE, CAL_PIN, CHAN_I_DOWN_PIN,
  input logic        CAL_START, FIXED_PATTERN_ENABLE, SLOW_CLOCK_SELECT, CHAN_I_POWERDOWN
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  wire ext_mode = EXTENDED_CONTROL_MODE;
  sequence s_arm; (ext_mode && !CAL_PIN && !MAIN_CONFIG[15])[*4]; endsequence
  sequence s_bit; ##1 $rose(MAIN_CONFIG[15]); endsequence
  sequence s_pin; (!CAL_PIN && !MAIN_CONFIG[15])[*4] ##1 $rose(CAL_PIN); endsequence
  AST_RVALID: assert property (REG_RD |=> REG_RVALID) else $error("no read answer");
  AST_RD_MAIN: assert property (REG_RD && REG_ADDR == 4'h0 |=> REG_RDATA == $past(MAIN_CONFIG))
    else $error("bad main read");
  AST_RD_RSVD: assert property (REG_RD && REG_ADDR inside {[4'h5:4'h9], 4'hF} |=> REG_RDATA == 16'h0000)
    else $error("reserved read not zero");
  AST_WR_MAIN: assert property (REG_WR && REG_ADDR == 4'h0 |=> MAIN_CONFIG == ($past(REG_WDATA) & 16'hFDF0))
    else $error("bad main write");
  AST_HOLD: assert property (!(REG_WR && REG_ADDR == 4'h0) |=> $stable(MAIN_CONFIG))
    else $error("main changed unasked");
  AST_PATTERN: assert property (ext_mode[*8] |-> FIXED_PATTERN_ENABLE == $past(MAIN_CONFIG[12]))
    else $error("bad pattern enable");
  AST_PINMODE: assert property ((!ext_mode)[*8] |-> !FIXED_PATTERN_ENABLE && !SLOW_CLOCK_SELECT)
    else $error("register used in pin mode");
  AST_IDOWN: assert property (CHAN_I_DOWN_PIN[*6] |-> CHAN_I_POWERDOWN) else $error("pin ignored");
  AST_CAL: assert property (s_arm ##0 s_bit |-> ##[1:2] CAL_START) else $error("no cal start");
  AST_CAL_ONE: assert property (CAL_START |=> !CAL_START) else $error("cal start too long");
  AST_CAL_PIN: assert property (s_pin |-> ##[2:5] CAL_START) else $error("pin cal missed");
endmodule // acrb_chk
bind acrb_top acrb_chk u_chk (.CLK_SYS, .RSTN, .REG_WR, .REG_RD, .REG_RVALID, .REG_ADDR, .REG_WDATA,
  .REG_RDATA, .MAIN_CONFIG, .EXTENDED_CONTROL_MODE, .CAL_PIN, .CHAN_I_DOWN_PIN, .CAL_START,
  .FIXED_PATTERN_ENABLE, .SLOW_CLOCK_SELECT, .CHAN_I_POWERDOWN);

// [acrb_host.sv]
/* Host model writing and reading words on the register port.
   Assumes the bench calls its tasks from one process. */
`timescale 1ns/10ps
module acrb_host (
  input  logic        clk,
  output logic        wr, rd,
  output logic [3:0]  addr,
  output logic [15:0] wdata,
  input  logic        rvalid,
  input  logic [15:0] rdata
);
  initial begin
    wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 16'h0000;
  end
  // One word per access; data turns over once released.
  task automatic put(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1; addr = a; wdata = d;
    @(negedge clk);
    wr = 1'b0; wdata = ~d;
  endtask
  task automatic get(input logic [3:0] a, output logic [15:0] d);
    int n;
    @(negedge clk);
    rd = 1'b1; addr = a;
    @(negedge clk);
    rd = 1'b0; n = 0;
    while (rvalid !== 1'b1 && n < 4) begin @(negedge clk); n++; end
    d = (n < 4) ? rdata : 16'hxxxx;
  endtask
endmodule // acrb_host

// [acrb_map.vh]
/*
  Register offsets, field positions and reset values of the converter
  control register bank. Assumes inclusion by bare name from design files.
*/
`ifndef ACRB_MAP_VH
`define ACRB_MAP_VH
`define ACRB_ADDR_W          4
`define ACRB_DATA_W          16
`define ACRB_OFS_MAIN        4'h0
`define ACRB_OFS_VCM         4'h1
`define ACRB_OFS_IOFS        4'h2
`define ACRB_OFS_IRNG        4'h3
`define ACRB_OFS_TRIM        4'h4
`define ACRB_OFS_QOFS        4'hA
`define ACRB_OFS_QRNG        4'hB
`define ACRB_OFS_APC         4'hC
`define ACRB_OFS_APF         4'hD
`define ACRB_OFS_SYNC        4'hE
`define ACRB_MAIN_RESET      16'h2000
`define ACRB_MAIN_WMASK      16'hFDF0
`define ACRB_GEN_RESET       16'h0000
`define ACRB_BIT_CAL         15
`define ACRB_BIT_PHASE       14
`define ACRB_BIT_OVS         13
`define ACRB_BIT_PATTERN     12
`define ACRB_BIT_IDOWN       11
`define ACRB_BIT_QDOWN       10
`define ACRB_BIT_SLOW        8
`define ACRB_BIT_DES         7
`define ACRB_BIT_PICK        6
`define ACRB_BIT_JOIN        5
`define ACRB_BIT_FMT         4
`endif

// [acrb_top.v]
/*
  Control register bank of a dual-channel converter: sixteen-location
  decode, main configuration register and the decoded control outputs.
  Assumes a host writing words over a simple address/strobe port that is
  synchronous to CLK_SYS; the calibration and power-down pins are async.
*/
`timescale 1ns/10ps
`include "acrb_map.vh"
module acrb_top (
  input  wire        CLK_SYS,
  input  wire        RSTN,
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [3:0]  REG_ADDR,
  input  wire [15:0] REG_WDATA,
  output reg  [15:0] REG_RDATA,
  output reg         REG_RVALID,
  input  wire        EXTENDED_CONTROL_MODE,
  input  wire        CAL_PIN,
  input  wire        CHAN_I_DOWN_PIN,
  input  wire        CHAN_Q_DOWN_PIN,
  input  wire        DEMUX_PIN,
  input  wire        DES_PIN,
  input  wire        OVS_PIN,
  input  wire        FMT_PIN,
  output reg         CAL_START,
  output reg         DDR_PHASE_SELECT,
  output reg         OUTPUT_SWING_HIGH,
  output reg         FIXED_PATTERN_ENABLE,
  output reg         CHAN_I_POWERDOWN,
  output reg         CHAN_Q_POWERDOWN,
  output reg         SLOW_CLOCK_SELECT,
  output reg         DUAL_EDGE_MODE,
  output reg         DUAL_EDGE_INPUT_PICK,
  output reg         DUAL_EDGE_INPUT_JOIN,
  output reg         SIGNED_OUTPUT_FORMAT,
  output wire [15:0] MAIN_CONFIG
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.
  reg        rst_meta;
  reg        rst_n;
  reg  [6:0] pin_meta;
  reg  [6:0] pin_sync;
  reg        cal_trig_q;

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
    end else begin
      pin_meta <= {EXTENDED_CONTROL_MODE, CAL_PIN, CHAN_I_DOWN_PIN, CHAN_Q_DOWN_PIN, DES_PIN, OVS_PIN, FMT_PIN};
      pin_sync <= pin_meta;
    end
  end

  wire ext_mode  = pin_sync[6];
  wire cal_pin   = pin_sync[5];
  wire idown_pin = pin_sync[4];
  wire qdown_pin = pin_sync[3];
  wire des_pin = pin_sync[2];
  wire ovs_pin = pin_sync[1];
  wire fmt_pin = pin_sync[0];
  reg        demux_meta;
  reg        demux_sync;

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      demux_meta <= 1'b0;
      demux_sync <= 1'b0;
    end else begin
      demux_meta <= DEMUX_PIN;
      demux_sync <= demux_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and storage.
  function is_stored;
    input [3:0] addr;
    begin
      case (addr)
        `ACRB_OFS_MAIN, `ACRB_OFS_VCM, `ACRB_OFS_IOFS, `ACRB_OFS_IRNG,
        `ACRB_OFS_TRIM, `ACRB_OFS_QOFS, `ACRB_OFS_QRNG, `ACRB_OFS_APC,
        `ACRB_OFS_APF, `ACRB_OFS_SYNC: is_stored = 1'b1;
        default: is_stored = 1'b0;
      endcase
    end
  endfunction

  wire [15:0] main_value;
  reg  [15:0] other_regs [0:15];
  integer     idx;

  acrb_word #(
    .RESET_VALUE (`ACRB_MAIN_RESET),
    .WRITE_MASK  (`ACRB_MAIN_WMASK)
  ) u_main (
    .clk     (CLK_SYS),
    .rst_n   (rst_n),
    .wr_en   (REG_WR && (REG_ADDR == `ACRB_OFS_MAIN)),
    .wr_data (REG_WDATA),
    .value   (main_value)
  );

  assign MAIN_CONFIG = main_value;

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      for (idx = 0; idx < 16; idx = idx + 1) begin
        other_regs[idx] <= `ACRB_GEN_RESET;
      end
    end else if (REG_WR && is_stored(REG_ADDR) && (REG_ADDR != `ACRB_OFS_MAIN)) begin
      other_regs[REG_ADDR] <= REG_WDATA;
    end
  end

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      REG_RDATA  <= 16'h0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        if (REG_ADDR == `ACRB_OFS_MAIN) begin
          REG_RDATA <= main_value;
        end else if (is_stored(REG_ADDR)) begin
          REG_RDATA <= other_regs[REG_ADDR];
        end else begin
          REG_RDATA <= 16'h0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective controls: register in extended mode (phase select gated by demux pin), pins or zero otherwise; cal and power-down pins act in both modes.
  wire cal_trig = (ext_mode & main_value[`ACRB_BIT_CAL]) | cal_pin;

  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cal_trig_q           <= 1'b0;
      CAL_START            <= 1'b0;
      DDR_PHASE_SELECT     <= 1'b0;
      OUTPUT_SWING_HIGH    <= 1'b0;
      FIXED_PATTERN_ENABLE <= 1'b0;
      CHAN_I_POWERDOWN     <= 1'b0;
      CHAN_Q_POWERDOWN     <= 1'b0;
      SLOW_CLOCK_SELECT    <= 1'b0;
      DUAL_EDGE_MODE       <= 1'b0;
      DUAL_EDGE_INPUT_PICK <= 1'b0;
      DUAL_EDGE_INPUT_JOIN <= 1'b0;
      SIGNED_OUTPUT_FORMAT <= 1'b0;
    end else begin
      cal_trig_q <= cal_trig;
      CAL_START  <= cal_trig & ~cal_trig_q;
      CHAN_I_POWERDOWN <= idown_pin | (ext_mode & main_value[`ACRB_BIT_IDOWN]);
      CHAN_Q_POWERDOWN <= qdown_pin | (ext_mode & main_value[`ACRB_BIT_QDOWN]);
      if (ext_mode) begin
        DDR_PHASE_SELECT     <= demux_sync & main_value[`ACRB_BIT_PHASE];
        OUTPUT_SWING_HIGH    <= main_value[`ACRB_BIT_OVS];
        FIXED_PATTERN_ENABLE <= main_value[`ACRB_BIT_PATTERN];
        SLOW_CLOCK_SELECT    <= main_value[`ACRB_BIT_SLOW];
        DUAL_EDGE_MODE       <= main_value[`ACRB_BIT_DES];
        DUAL_EDGE_INPUT_PICK <= main_value[`ACRB_BIT_DES] & main_value[`ACRB_BIT_PICK];
        DUAL_EDGE_INPUT_JOIN <= main_value[`ACRB_BIT_DES] & main_value[`ACRB_BIT_JOIN]
                                & ~main_value[`ACRB_BIT_PICK];
        SIGNED_OUTPUT_FORMAT <= main_value[`ACRB_BIT_FMT];
      end else begin
        DDR_PHASE_SELECT     <= 1'b0;
        OUTPUT_SWING_HIGH    <= ovs_pin;
        FIXED_PATTERN_ENABLE <= 1'b0;
        SLOW_CLOCK_SELECT    <= 1'b0;
        DUAL_EDGE_MODE       <= des_pin;
        DUAL_EDGE_INPUT_PICK <= 1'b0;
        DUAL_EDGE_INPUT_JOIN <= 1'b0;
        SIGNED_OUTPUT_FORMAT <= fmt_pin;
      end
    end
  end

endmodule // acrb_top

// [acrb_word.v]
/*
  One 16-bit storage word with write mask and reset value.
  Assumes a synchronised active-low reset from the top module.
*/
`timescale 1ns/10ps
module acrb_word #(
  parameter [15:0] RESET_VALUE = 16'h0000,
  parameter [15:0] WRITE_MASK  = 16'hFFFF
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        wr_en,
  input  wire [15:0] wr_data,
  output reg  [15:0] value
);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= RESET_VALUE;
    end else if (wr_en) begin
      value <= wr_data & WRITE_MASK;
    end
  end

endmodule // acrb_word

// [adc_config_register_bank_bench.sv]
/* Self-checking bench of the register bank.
   Assumes acrb_top, its checker and the host model. */
`timescale 1ns/10ps
module adc_config_register_bank_bench;
  logic clk = 1'b0, rstn = 1'b0, ext = 1'b0, cal = 1'b0, idn = 1'b0, qdn = 1'b0;
  logic dmx = 1'b1, des = 1'b0, ovs = 1'b0, fmt = 1'b0, wr, rd, rv, cs, dp, sw, tp, pi, pq, lf, de, pk, jn, sf;
  logic [3:0] ad;
  logic [15:0] wd, rdat, mc, got;
  int failures = 0, num_checks = 0;
  always #10 clk = ~clk;
  acrb_host u_host (.clk(clk), .wr(wr), .rd(rd), .addr(ad), .wdata(wd), .rvalid(rv), .rdata(rdat));
  acrb_top u_dut (.CLK_SYS(clk), .RSTN(rstn), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(ad), .REG_WDATA(wd),
    .REG_RDATA(rdat), .REG_RVALID(rv), .EXTENDED_CONTROL_MODE(ext), .CAL_PIN(cal), .CHAN_I_DOWN_PIN(idn),
    .CHAN_Q_DOWN_PIN(qdn), .DEMUX_PIN(dmx), .DES_PIN(des), .OVS_PIN(ovs), .FMT_PIN(fmt), .CAL_START(cs),
    .DDR_PHASE_SELECT(dp), .OUTPUT_SWING_HIGH(sw), .FIXED_PATTERN_ENABLE(tp), .CHAN_I_POWERDOWN(pi),
    .CHAN_Q_POWERDOWN(pq), .SLOW_CLOCK_SELECT(lf), .DUAL_EDGE_MODE(de), .DUAL_EDGE_INPUT_PICK(pk),
    .DUAL_EDGE_INPUT_JOIN(jn), .SIGNED_OUTPUT_FORMAT(sf), .MAIN_CONFIG(mc));
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin failures++; $display("BAD %s expected %h seen %h", what, e, s); end
  endtask
  task automatic idle(input int n); repeat (n) @(negedge clk); endtask
  task automatic t_reset;
    chk("main", 16'h2000, mc);
    u_host.get(4'h0, got); chk("main read", 16'h2000, got);
  endtask
  task automatic t_map;
    logic [15:0] e;
    for (int a = 0; a < 16; a++) u_host.put(a[3:0], 16'hA5A5 ^ 16'(a));
    for (int a = 0; a < 16; a++) begin
      u_host.get(a[3:0], got);
      e = (a inside {[5:9], 15}) ? 16'h0000 : (16'hA5A5 ^ 16'(a)) & (a == 0 ? 16'hFDF0 : 16'hFFFF);
      chk("readback", e, got);
    end
  endtask
  task automatic t_fields(input logic e);
    logic [15:0] t [11] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0100, 16'h0080,
      16'h00C0, 16'h00A0, 16'h00E0, 16'h0010};
    ext = e; ovs = !e; des = !e; fmt = !e; idn = !e;
    foreach (t[i]) begin
      u_host.put(4'h0, t[i]); idle(5);
      chk("controls", {6'h00, e & dmx & t[i][14], e ? t[i][13] : ovs, e & t[i][12], idn | e & t[i][11],
        qdn | e & t[i][10], e & t[i][8], e ? t[i][7] : des, e & t[i][7] & t[i][6],
        e & t[i][7] & t[i][5] & ~t[i][6], e ? t[i][4] : fmt},
        {6'h00, dp, sw, tp, pi, pq, lf, de, pk, jn, sf});
    end
  endtask
  task automatic pulses(output int n);
    n = 0;
    repeat (8) begin @(negedge clk); if (cs === 1'b1) n++; end
  endtask
  task automatic t_cal;
    int h;
    ext = 1'b1; cal = 1'b0; u_host.put(4'h0, 16'h0000); idle(5);
    u_host.put(4'h0, 16'h8000); pulses(h); chk("cal bit", 16'h0001, 16'(h));
    u_host.put(4'h0, 16'h8000); pulses(h); chk("cal again", 16'h0000, 16'(h));
    u_host.put(4'h0, 16'h0000); idle(5); cal = 1'b1; pulses(h); chk("cal pin", 16'h0001, 16'(h));
    cal = 1'b0; idn = 1'b1; idle(5); chk("pin power", 16'h0001, {15'h0000, pi});
    idn = 1'b0; qdn = 1'b1; dmx = 1'b0; u_host.put(4'h0, 16'h4000); idle(5);
    chk("demux off", 16'h0001, {14'h0000, dp, pq});
  endtask
  task automatic report_and_stop;
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    idle(20); rstn = 1'b1; idle(3);
    t_reset; t_map; t_fields(1'b1); t_fields(1'b0); t_cal;
    report_and_stop;
  end
  initial begin #200000; failures++; report_and_stop; end
endmodule // adc_config_register_bank_bench
